// ==== core/spiqh_defs.vh ====
`ifndef SPIQH_DEFS_VH
`define SPIQH_DEFS_VH
// device register offsets
`define SPIQH_OFS_CTL0 8'h00
`define SPIQH_OFS_CTL1 8'h04
`define SPIQH_OFS_STAT 8'h08
`define SPIQH_OFS_DATA 8'h0c
`define SPIQH_OFS_CRCPOLY 8'h10
`define SPIQH_OFS_RXCRC 8'h14
`define SPIQH_OFS_TXCRC 8'h18
`define SPIQH_OFS_QCTL 8'h80
// control word 0 fields
`define SPIQH_CTL0_PORT_EN 6
`define SPIQH_CTL0_CRC_NEXT 12
`define SPIQH_CTL0_CRC_EN 13
`define SPIQH_CTL0_CRC_LEN 11
// control word 1 fields
`define SPIQH_CTL1_FRAME_LO 8
`define SPIQH_CTL1_FRAME_HI 11
`define SPIQH_CTL1_BYTE_ACC 12
`define SPIQH_CTL1_TX_ODD 14
`define SPIQH_CTL1_RX_ODD 13
`define SPIQH_CTL1_MERGE 15
`define SPIQH_FRAME_8BIT 4'h7
// status fields
`define SPIQH_STAT_RX_NE 0
`define SPIQH_STAT_TX_EMPTY 1
`define SPIQH_STAT_BUSY 7
`define SPIQH_STAT_RX_FIFO_LEVEL_LO 9
`define SPIQH_STAT_RX_FIFO_LEVEL_HI 10
`define SPIQH_STAT_TX_FIFO_LEVEL_LO 11
`define SPIQH_STAT_TX_FIFO_LEVEL_HI 12
// quad control fields
`define SPIQH_QCTL_QUAD_MODE 0
`define SPIQH_QCTL_QUAD_READ 1
// arbitrary value written only to make clocks
`define SPIQH_DUMMY_BYTE 16'h00ff
// fallback bound on the serial clock wait, in clk cycles
`define SPIQH_SCK_WAIT_MAX 16'h0100
// operations
`define SPIQH_OP_QREAD 3'h0
`define SPIQH_OP_DISABLE 3'h1
`define SPIQH_OP_CRC_NEXT 3'h2
`define SPIQH_OP_SETUP 3'h3
// disabling modes
`define SPIQH_MD_FULL_DUPLEX 3'h0
`define SPIQH_MD_TX_ONLY 3'h1
`define SPIQH_MD_MASTER_RX 3'h2
`define SPIQH_MD_SLAVE_RX 3'h3
`endif

// ==== core/spiqh_ctrl.v ====
`timescale 1ns/1ps
`include "spiqh_defs.vh"
module spiqh_ctrl #(
	parameter DW = 16,
	parameter CW = 16
) (
	input wire clk,
	input wire nrst,
	input wire cmdValid,
	output wire cmdReady,
	input wire [2:0] cmdOp,
	input wire [2:0] cmdMode,
	input wire cmdFifo,
	input wire [CW-1:0] cmdCount,
	input wire [DW-1:0] cmdData,
	output reg doneValid,
	output wire rxValid,
	input wire rxReady,
	output wire [DW-1:0] rxData,
	output reg [CW-1:0] rxDmaCount,
	output wire [7:0] devAddr,
	output wire [DW-1:0] devWdata,
	output wire devWr,
	output wire devRd,
	input wire [DW-1:0] devRdata,
	input wire devAck,
	input wire sckPin
);
	localparam S_IDLE = 4'h0;
	localparam S_ACC = 4'h1;
	localparam S_QEN = 4'h2;
	localparam S_QWR = 4'h3;
	localparam S_QPOLL = 4'h4;
	localparam S_PUSH = 4'h5;
	localparam S_QEND = 4'h6;
	localparam S_QOFF = 4'h7;
	localparam S_POLL = 4'h8;
	localparam S_OFF = 4'h9;
	localparam S_AFTER = 4'ha;
	localparam S_DRAIN = 4'hb;
	localparam S_SCKW = 4'hc;
	localparam S_DONE = 4'hd;

	// receive DMA channel length for a CRC-protected transfer
	function [CW-1:0] rxCountCalc;
		input [CW-1:0] len;
		input crc16;
		input frame8;
		input duplex;
		begin
			if (!duplex)
				rxCountCalc = len;
			else if (!crc16 && frame8)
				rxCountCalc = len + {{(CW-1){1'b0}}, 1'b1};
			else
				rxCountCalc = len + {{(CW-2){1'b0}}, 2'b10};
		end
	endfunction

	// one-hot mask for a single control bit
	function [DW-1:0] bitMask;
		input integer pos;
		begin
			bitMask = {{(DW-1){1'b0}}, 1'b1} << pos;
		end
	endfunction

	reg [3:0] state;
	reg [3:0] retState;
	reg [7:0] accAddr;
	reg [DW-1:0] accData;
	reg accWrite;
	reg [DW-1:0] rdWord;
	reg [2:0] op;
	reg [2:0] mode;
	reg fifoDev;
	reg [CW-1:0] left;
	reg [DW-1:0] ctlImage;
	reg phase;
	reg [15:0] waitCnt;
	reg [1:0] sckEdges;
	reg [2:0] sckSync;
	reg sckStable;
	reg pushReq;

	// two-entry receive buffer
	reg [DW-1:0] bufMem [0:1];
	reg bufWp;
	reg bufRp;
	reg [1:0] bufCnt;
	wire bufFull = (bufCnt == 2'd2);
	wire bufPush = pushReq && !bufFull;
	wire bufPop = rxValid && rxReady;
	assign rxValid = (bufCnt != 2'd0);
	assign rxData = bufMem[bufRp];

	always @(posedge clk) begin
		if (!nrst) begin
			bufWp <= 1'b0;
			bufRp <= 1'b0;
			bufCnt <= 2'd0;
		end else begin
			if (bufPush) begin
				bufMem[bufWp] <= rdWord;
				bufWp <= ~bufWp;
			end
			if (bufPop)
				bufRp <= ~bufRp;
			if (bufPush && !bufPop)
				bufCnt <= bufCnt + 2'd1;
			else if (bufPop && !bufPush)
				bufCnt <= bufCnt - 2'd1;
		end
	end

	// serial clock seen through three flops; edge once second and third agree
	always @(posedge clk) begin
		if (!nrst) begin
			sckSync <= 3'b000;
			sckStable <= 1'b0;
		end else begin
			sckSync <= {sckSync[1:0], sckPin};
			if (sckSync[1] == sckSync[2])
				sckStable <= sckSync[2];
		end
	end
	wire sckRise = (sckSync[1] == sckSync[2]) && sckSync[2] && !sckStable;

	assign cmdReady = (state == S_IDLE);
	assign devAddr = accAddr;
	assign devWdata = accData;
	assign devWr = (state == S_ACC) && accWrite;
	assign devRd = (state == S_ACC) && !accWrite;

	wire statRxNe = rdWord[`SPIQH_STAT_RX_NE];
	wire statTxE = rdWord[`SPIQH_STAT_TX_EMPTY];
	wire statBusy = rdWord[`SPIQH_STAT_BUSY];
	wire txLvlZero = (rdWord[`SPIQH_STAT_TX_FIFO_LEVEL_HI:`SPIQH_STAT_TX_FIFO_LEVEL_LO] == 2'b00);
	wire rxLvlZero = (rdWord[`SPIQH_STAT_RX_FIFO_LEVEL_HI:`SPIQH_STAT_RX_FIFO_LEVEL_LO] == 2'b00);
	wire txDrained = statTxE && !statBusy && (!fifoDev || txLvlZero);
	wire [DW-1:0] ctlOff = ctlImage & ~bitMask(`SPIQH_CTL0_PORT_EN);
	wire merge = cmdData[`SPIQH_CTL1_MERGE];
	wire frame8 = (cmdData[`SPIQH_CTL1_FRAME_HI:`SPIQH_CTL1_FRAME_LO] ==
		`SPIQH_FRAME_8BIT);

	always @(posedge clk) begin
		if (!nrst) begin
			state <= S_IDLE;
			retState <= S_IDLE;
			accAddr <= 8'h00;
			accData <= {DW{1'b0}};
			accWrite <= 1'b0;
			rdWord <= {DW{1'b0}};
			op <= 3'h0;
			mode <= 3'h0;
			fifoDev <= 1'b0;
			left <= {CW{1'b0}};
			ctlImage <= {DW{1'b0}};
			phase <= 1'b0;
			waitCnt <= 16'h0000;
			sckEdges <= 2'd0;
			pushReq <= 1'b0;
			doneValid <= 1'b0;
			rxDmaCount <= {CW{1'b0}};
		end else begin
			doneValid <= 1'b0;
			case (state)
			S_IDLE: begin
				if (cmdValid) begin
					op <= cmdOp;
					mode <= cmdMode;
					fifoDev <= cmdFifo;
					left <= cmdCount;
					phase <= 1'b0;
					accWrite <= 1'b1;
					case (cmdOp)
					`SPIQH_OP_QREAD: begin
						// quad read select turns all lines to inputs
						accAddr <= `SPIQH_OFS_QCTL;
						accData <= ({{(DW-1){1'b0}}, 1'b1} << `SPIQH_QCTL_QUAD_MODE) |
							({{(DW-1){1'b0}}, 1'b1} << `SPIQH_QCTL_QUAD_READ);
						ctlImage <= cmdData;
						retState <= S_QEN;
						state <= S_ACC;
					end
					`SPIQH_OP_CRC_NEXT: begin
						// request CRC after the final word
						accAddr <= `SPIQH_OFS_CTL0;
						accData <= ctlImage |
							({{(DW-1){1'b0}}, 1'b1} << `SPIQH_CTL0_CRC_NEXT);
						retState <= S_DONE;
						state <= S_ACC;
					end
					`SPIQH_OP_SETUP: begin
						accAddr <= `SPIQH_OFS_CTL1;
						accData <= (merge && cmdCount[0]) ? (cmdData |
							({{(DW-1){1'b0}}, 1'b1} << `SPIQH_CTL1_TX_ODD) |
							({{(DW-1){1'b0}}, 1'b1} << `SPIQH_CTL1_RX_ODD)) :
							cmdData;
						// receive DMA count with CRC frames
						rxDmaCount <= rxCountCalc(cmdCount,
							ctlImage[`SPIQH_CTL0_CRC_LEN], frame8,
							cmdMode == `SPIQH_MD_FULL_DUPLEX);
						retState <= S_DONE;
						state <= S_ACC;
					end
					default: begin
						ctlImage <= cmdData;
						if (cmdMode == `SPIQH_MD_SLAVE_RX) begin
							// slave receive may stop at once
							accAddr <= `SPIQH_OFS_CTL0;
							accData <= cmdData & ~({{(DW-1){1'b0}}, 1'b1} <<
								`SPIQH_CTL0_PORT_EN);
							retState <= S_POLL;
							phase <= 1'b1;
							state <= S_ACC;
						end else if (cmdMode == `SPIQH_MD_MASTER_RX) begin
							waitCnt <= 16'h0000;
							sckEdges <= 2'd0;
							state <= S_SCKW;
						end else begin
							accWrite <= 1'b0;
							accAddr <= `SPIQH_OFS_STAT;
							retState <= S_POLL;
							state <= S_ACC;
						end
					end
					endcase
				end
			end
			S_ACC: begin
				if (devAck) begin
					if (!accWrite)
						rdWord <= devRdata;
					state <= retState;
				end
			end
			S_QEN: begin
				accAddr <= `SPIQH_OFS_CTL0;
				accData <= ctlImage | bitMask(`SPIQH_CTL0_PORT_EN);
				ctlImage <= ctlImage | bitMask(`SPIQH_CTL0_PORT_EN);
				retState <= (left == {CW{1'b0}}) ? S_QEND : S_QWR;
				state <= S_ACC;
			end
			S_QWR: begin
				// dummy write only clocks in one byte
				accWrite <= 1'b1;
				accAddr <= `SPIQH_OFS_DATA;
				accData <= `SPIQH_DUMMY_BYTE;
				retState <= S_QPOLL;
				phase <= 1'b0;
				state <= S_ACC;
			end
			S_QPOLL: begin
				accWrite <= 1'b0;
				if (phase && statRxNe) begin
					accAddr <= `SPIQH_OFS_DATA;
					retState <= S_PUSH;
				end else begin
					accAddr <= `SPIQH_OFS_STAT;
					retState <= S_QPOLL;
				end
				phase <= 1'b1;
				state <= S_ACC;
			end
			S_PUSH: begin
				// back-pressure: the device is not read again until the word fits
				pushReq <= 1'b1;
				if (bufPush) begin
					pushReq <= 1'b0;
					if (op == `SPIQH_OP_QREAD) begin
						left <= left - {{(CW-1){1'b0}}, 1'b1};
						phase <= 1'b0;
						state <= (left == {{(CW-1){1'b0}}, 1'b1}) ? S_QEND : S_QWR;
					end else begin
						state <= S_AFTER;
					end
				end
			end
			S_QEND: begin
				// quad mode left only once empty and idle
				accWrite <= 1'b0;
				accAddr <= `SPIQH_OFS_STAT;
				retState <= phase && statTxE && !statBusy ? S_QOFF : S_QEND;
				if (phase && statTxE && !statBusy) begin
					accWrite <= 1'b1;
					accAddr <= `SPIQH_OFS_QCTL;
					accData <= {DW{1'b0}};
					retState <= S_QOFF;
				end
				phase <= 1'b1;
				state <= S_ACC;
				if (phase && statTxE && !statBusy && accAddr == `SPIQH_OFS_QCTL)
					state <= S_OFF;
			end
			S_QOFF: begin
				accWrite <= 1'b1;
				accAddr <= `SPIQH_OFS_CTL0;
				accData <= ctlOff;
				ctlImage <= ctlOff;
				retState <= S_DONE;
				state <= S_ACC;
			end
			S_POLL: begin
				state <= S_ACC;
				accWrite <= 1'b0;
				accAddr <= `SPIQH_OFS_STAT;
				retState <= S_POLL;
				if (phase) begin
					if (mode == `SPIQH_MD_SLAVE_RX) begin
						// wait for the ongoing frame to end
						if (!statBusy && accAddr == `SPIQH_OFS_STAT)
							state <= fifoDev ? S_DRAIN : S_DONE;
					end else if (mode == `SPIQH_MD_FULL_DUPLEX && !fifoDev &&
						statRxNe) begin
						// take the last received word first
						accAddr <= `SPIQH_OFS_DATA;
						retState <= S_PUSH;
					end else if (txDrained) begin
						state <= S_OFF;
					end
				end
				phase <= 1'b1;
			end
			S_AFTER: begin
				// last read was data, so status must be fetched afresh
				phase <= 1'b0;
				if (mode == `SPIQH_MD_MASTER_RX)
					state <= fifoDev ? S_DRAIN : S_DONE;
				else if (fifoDev)
					state <= S_DRAIN;
				else
					state <= S_POLL;
			end
			S_OFF: begin
				accWrite <= 1'b1;
				accAddr <= `SPIQH_OFS_CTL0;
				accData <= ctlOff;
				ctlImage <= ctlOff;
				phase <= 1'b0;
				if (op == `SPIQH_OP_QREAD)
					retState <= S_DONE;
				else if (mode == `SPIQH_MD_MASTER_RX)
					retState <= S_QPOLL;
				else if (fifoDev && mode == `SPIQH_MD_FULL_DUPLEX)
					retState <= S_DRAIN;
				else
					retState <= S_DONE;
				state <= S_ACC;
			end
			S_DRAIN: begin
				// read words until the receive level is zero
				accWrite <= 1'b0;
				state <= S_ACC;
				if (phase && accAddr == `SPIQH_OFS_STAT && rxLvlZero) begin
					state <= S_DONE;
				end else if (phase && accAddr == `SPIQH_OFS_STAT) begin
					accAddr <= `SPIQH_OFS_DATA;
					retState <= S_PUSH;
					mode <= `SPIQH_MD_SLAVE_RX;
				end else begin
					accAddr <= `SPIQH_OFS_STAT;
					retState <= S_DRAIN;
				end
				phase <= 1'b1;
			end
			S_SCKW: begin
				// one full serial clock before clearing enable
				waitCnt <= waitCnt + 16'h0001;
				if (sckRise)
					sckEdges <= sckEdges + 2'd1;
				if (sckEdges == 2'd2 || waitCnt == `SPIQH_SCK_WAIT_MAX)
					state <= S_OFF;
			end
			S_DONE: begin
				doneValid <= 1'b1;
				state <= S_IDLE;
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // spiqh_ctrl

// ==== bench/spiqh_properties.sv ====
`timescale 1ns/1ps
`include "spiqh_defs.vh"
module spiqh_properties #(
	parameter DW = 16,
	parameter CW = 16
) (
	input wire clk,
	input wire nrst,
	input wire cmdValid,
	input wire cmdReady,
	input wire [2:0] cmdOp,
	input wire doneValid,
	input wire rxValid,
	input wire rxReady,
	input wire [DW-1:0] rxData,
	input wire [7:0] devAddr,
	input wire [DW-1:0] devWdata,
	input wire devWr,
	input wire devRd,
	input wire [DW-1:0] devRdata,
	input wire devAck
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	reg okIdle;
	reg qOn;
	// idle proof must come after the last data write
	always @(posedge clk) begin
		if (!nrst) begin
			okIdle <= 1'b0;
			qOn <= 1'b0;
		end else if (devAck) begin
			if (devRd && devAddr == `SPIQH_OFS_STAT)
				okIdle <= devRdata[1] && !devRdata[7];
			if (devWr && devAddr == `SPIQH_OFS_DATA)
				okIdle <= 1'b0;
			if (devWr && devAddr == `SPIQH_OFS_QCTL)
				qOn <= devWdata != 16'h0000;
		end
	end
	sequence s_crcTake;
		cmdValid && cmdReady && cmdOp == `SPIQH_OP_CRC_NEXT;
	endsequence
	sequence s_crcWrite;
		devWr && devAddr == `SPIQH_OFS_CTL0 && devWdata[`SPIQH_CTL0_CRC_NEXT];
	endsequence
	a_crc_next_write: assert property (s_crcTake |=> s_crcWrite)
		else $error("crc-next command did not write control word");
	a_dummy_data: assert property (devWr && devAddr == `SPIQH_OFS_DATA
		|-> devWdata == `SPIQH_DUMMY_BYTE)
		else $error("data write without dummy value");
	a_quad_exit: assert property (devWr && devAddr == `SPIQH_OFS_QCTL
		&& devWdata == 16'h0000 && qOn |-> okIdle)
		else $error("quad mode left before empty and idle");
	a_write_hold: assert property (devWr && !devAck
		|=> devWr && $stable(devAddr) && $stable(devWdata))
		else $error("write released before acknowledge");
	a_read_hold: assert property (devRd && !devAck |=> devRd && $stable(devAddr))
		else $error("read released before acknowledge");
	a_access_gap: assert property ((devWr || devRd) && devAck
		|=> !devWr && !devRd)
		else $error("no idle cycle after access");
	a_one_strobe: assert property (!(devWr && devRd))
		else $error("read and write together");
	a_take_busy: assert property (cmdValid && cmdReady |=> !cmdReady [*2])
		else $error("ready while command runs");
	a_done_pulse: assert property (doneValid |=> !doneValid)
		else $error("done longer than one cycle");
	a_rx_hold: assert property (rxValid && !rxReady
		|=> rxValid && $stable(rxData))
		else $error("receive word changed while stalled");
endmodule // spiqh_properties
bind spiqh_ctrl spiqh_properties #(.DW(DW), .CW(CW)) u_chk (.clk(clk),
	.nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
	.doneValid(doneValid), .rxValid(rxValid), .rxReady(rxReady),
	.rxData(rxData), .devAddr(devAddr), .devWdata(devWdata), .devWr(devWr),
	.devRd(devRd), .devRdata(devRdata), .devAck(devAck));

// ==== bench/spiqh_dev_model.sv ====
`timescale 1ns/1ps
`include "spiqh_defs.vh"
module spiqh_dev_model (
	input wire clk,
	input wire nrst,
	input wire [7:0] devAddr,
	input wire [15:0] devWdata,
	input wire devWr,
	input wire devRd,
	output logic [15:0] devRdata,
	output logic devAck,
	output logic sckPin,
	input wire runFree
);
	logic [15:0] ctl0, ctl1, qctl;
	logic [15:0] q[$];
	logic [15:0] src[$];
	logic [1:0] lvl;
	logic quadSeen;
	int busy, div, wt, rises, offRises;
	always @(posedge clk) begin
		// released bus shows the inverse of the last value
		devAck <= 1'b0;
		devRdata <= ~devRdata;
		if (!ctl0[`SPIQH_CTL0_PORT_EN])
			busy = 0;
		if (busy != 0) begin
			busy = busy - 1;
			if (busy == 0 && qctl[1:0] == 2'b11) begin
				quadSeen <= 1'b1;
				q.push_back(src.size() != 0 ? src.pop_front() : 16'h0000);
			end
		end
		if (busy != 0 || runFree) begin
			div = div + 1;
			if (div == 4) begin
				div = 0;
				sckPin <= ~sckPin;
				rises = rises + !sckPin;
			end
		end else
			sckPin <= 1'b0;
		lvl = q.size() > 3 ? 2'h3 : 2'(q.size());
		if ((devWr || devRd) && !devAck && wt != 0)
			wt = wt - 1;
		else if ((devWr || devRd) && !devAck) begin
			devAck <= 1'b1;
			wt = $urandom_range(3);
			// no DMA enable is ever written, so no request
			// crc enable and length kept as written
			if (devWr && devAddr == `SPIQH_OFS_CTL0) begin
				if (!devWdata[`SPIQH_CTL0_PORT_EN])
					offRises = rises;
				ctl0 <= devWdata;
			end
			// frame size, merge and odd bits kept
			if (devWr && devAddr == `SPIQH_OFS_CTL1)
				ctl1 <= devWdata;
			if (devWr && devAddr == `SPIQH_OFS_QCTL)
				qctl <= devWdata;
			if (devWr && devAddr == `SPIQH_OFS_DATA && ctl0[6])
				busy = 16;
			if (devRd && devAddr == `SPIQH_OFS_STAT)
				devRdata <= {3'h0, busy != 0, 1'b0, lvl, 1'b0, busy != 0,
					5'h00, busy == 0, q.size() != 0};
			if (devRd && devAddr == `SPIQH_OFS_DATA)
				devRdata <= q.size() != 0 ? q.pop_front() : 16'h0000;
		end
		if (!nrst) begin
			ctl0 <= 16'h0000;
			ctl1 <= 16'h0000;
			qctl <= 16'h0000;
			devRdata <= 16'h0000;
			sckPin <= 1'b0;
			quadSeen <= 1'b0;
			busy = 0;
			wt = 0;
			div = 0;
		end
	end
endmodule // spiqh_dev_model

// ==== bench/spiqh_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "spiqh_defs.vh"
module spiqh_ctrl_tb;
	logic clk = 0, nrst = 0, cmdValid = 0, cmdFifo = 0, rxReady = 0;
	logic runFree = 0, stall = 0, mg;
	logic [2:0] cmdOp = 0, cmdMode = 0;
	logic [15:0] cmdCount = 0, cmdData = 0, rxData, rxDmaCount;
	logic [15:0] devWdata, devRdata, exp[$];
	logic [7:0] devAddr;
	logic [3:0] fr;
	logic cmdReady, doneValid, rxValid, devWr, devRd, devAck, sckPin;
	int n_fail = 0, cmp_count = 0, j, m, L, e;
	initial forever #20 clk = ~clk;
	spiqh_ctrl DUT (.clk(clk), .nrst(nrst), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdOp(cmdOp), .cmdMode(cmdMode),
		.cmdFifo(cmdFifo), .cmdCount(cmdCount), .cmdData(cmdData),
		.doneValid(doneValid), .rxValid(rxValid), .rxReady(rxReady),
		.rxData(rxData), .rxDmaCount(rxDmaCount), .devAddr(devAddr),
		.devWdata(devWdata), .devWr(devWr), .devRd(devRd),
		.devRdata(devRdata), .devAck(devAck), .sckPin(sckPin));
	spiqh_dev_model dev (.clk(clk), .nrst(nrst), .devAddr(devAddr),
		.devWdata(devWdata), .devWr(devWr), .devRd(devRd),
		.devRdata(devRdata), .devAck(devAck), .sckPin(sckPin),
		.runFree(runFree));
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task cmd(input [2:0] op, input [2:0] md, input f, input [15:0] n,
		input [15:0] d);
		int k;
		while (cmdReady !== 1'b1)
			@(negedge clk);
		cmdOp = op;
		cmdMode = md;
		cmdFifo = f;
		cmdCount = n;
		cmdData = d;
		cmdValid = 1'b1;
		@(negedge clk);
		cmdValid = 1'b0;
		for (k = 0; k < 4000 && doneValid !== 1'b1; k++)
			@(negedge clk);
		chk("done", doneValid, 16'h0001);
	endtask
	task drain;
		int k;
		for (k = 0; k < 500 && exp.size() != 0; k++)
			@(negedge clk);
		chk("rx pending", exp.size(), 16'h0000);
	endtask
	always @(negedge clk)
		rxReady <= !stall && $urandom_range(3) != 0;
	always @(posedge clk)
		if (rxValid === 1'b1 && rxReady === 1'b1) begin
			if (exp.size() == 0)
				chk("rx extra", rxData, 16'hxxxx);
			else
				chk("rxData", rxData, exp.pop_front());
		end
	initial begin
		#2000000;
		n_fail++;
		test_done;
	end
	initial begin
		void'($urandom(50));
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		// receiver stalls first so the buffer fills
		stall = 1'b1;
		for (j = 0; j < 6; j++) begin
			e = $urandom_range(255);
			dev.src.push_back(e[15:0]);
			exp.push_back(e[15:0]);
		end
		fork
			cmd(`SPIQH_OP_QREAD, 3'h0, 1'b0, 16'h0006, 16'h0000);
			begin
				repeat (300) @(negedge clk);
				stall = 1'b0;
			end
		join
		drain;
		chk("quad lines", dev.quadSeen, 16'h0001);
		chk("qctl", dev.qctl, 16'h0000);
		chk("quad enable", dev.ctl0[6], 16'h0000);
		cmd(`SPIQH_OP_CRC_NEXT, 3'h0, 1'b0, 16'h0000, 16'h2000);
		chk("crc next", dev.ctl0[12], 16'h0001);
		for (j = 0; j < 8; j++) begin
			m = j % 4;
			if (m == 0 || m == 2 || j == 7) begin
				e = $urandom;
				dev.q.push_back(e[15:0]);
				exp.push_back(e[15:0]);
			end
			runFree = m == 2;
			dev.rises = 0;
			cmd(`SPIQH_OP_DISABLE, m[2:0], j >= 4, 16'h0000, 16'h0840);
			drain;
			chk("enable off", dev.ctl0[6], 16'h0000);
			chk("rx left", dev.q.size(), 16'h0000);
			if (m == 2)
				chk("sck wait", dev.offRises >= 1, 16'h0001);
		end
		runFree = 1'b0;
		for (j = 0; j < 8; j++) begin
			fr = j[1] ? 4'h7 : 4'hf;
			m = j[2] ? 2 : 0;
			mg = $urandom_range(1);
			L = $urandom_range(40, 1);
			cmd(`SPIQH_OP_DISABLE, 3'h1, 1'b1, 16'h0000, {4'h0, j[0], 11'h000});
			cmd(`SPIQH_OP_SETUP, m[2:0], 1'b1, L[15:0], {mg, 3'h0, fr, 8'h00});
			e = m != 0 ? L : (!j[0] && fr == 4'h7) ? L + 1 : L + 2;
			chk("dma count", rxDmaCount, e[15:0]);
			chk("odd bits", dev.ctl1[15:13], {mg, mg && L[0], mg && L[0]});
		end
		test_done;
	end
endmodule // spiqh_ctrl_tb
